// file: cfd_pkg.sv
// Shared constants, opcodes and state encodings of the control-flow core
package cfd_pkg;
    localparam int PC_W       = 15;
    localparam int UPPER_W    = 7;
    localparam int BYTE_W     = 8;
    localparam int PMEM_DEPTH = 32768;
    localparam int DMEM_DEPTH = 256;
    localparam int VEC_W      = 4;

    // Data memory map of the register-memory window
    localparam logic [7:0] REG_BASE = 8'hf0;
    localparam logic [7:0] X_ADDR   = 8'hfc;
    localparam logic [7:0] SP_ADDR  = 8'hfd;
    localparam logic [7:0] B_ADDR   = 8'hfe;
    localparam logic [7:0] SEG_ADDR = 8'hff;
    localparam logic [7:0] SP_RESET = 8'h6f;
    localparam logic [7:0] ONE_B    = 8'h01;
    localparam logic [7:0] TWO_B    = 8'h02;

    localparam logic [14:0] PC_RESET = 15'h0000;
    localparam logic [14:0] VEC_BASE = 15'h01e0;

    // Instruction lengths in bytes
    localparam logic [1:0] LEN1 = 2'h1;
    localparam logic [1:0] LEN2 = 2'h2;
    localparam logic [1:0] LEN3 = 2'h3;

    // Single opcodes
    localparam logic [7:0] OP_NOP  = 8'h00;
    localparam logic [7:0] OP_FARJ = 8'h01;
    localparam logic [7:0] OP_TABJ = 8'h02;
    localparam logic [7:0] OP_VSEL = 8'h03;
    localparam logic [7:0] OP_JSRL = 8'h04;
    localparam logic [7:0] OP_RTN  = 8'h05;
    localparam logic [7:0] OP_SC   = 8'h06;
    localparam logic [7:0] OP_RC   = 8'h07;
    localparam logic [7:0] OP_IFC  = 8'h08;
    localparam logic [7:0] OP_IFNC = 8'h09;
    localparam logic [7:0] OP_EI   = 8'h0a;
    localparam logic [7:0] OP_DI   = 8'h0b;
    localparam logic [7:0] OP_ST   = 8'h0c;
    localparam logic [7:0] OP_HALT = 8'h0d;

    // Opcode groups, selected by the upper nibble
    localparam logic [3:0] GRP_NEAR = 4'h2;
    localparam logic [3:0] GRP_LDR  = 4'h3;
    localparam logic [3:0] GRP_ADC  = 4'h4;
    localparam logic [3:0] GRP_LDA  = 4'h5;
    localparam logic [3:0] GRP_IFEQ = 4'h6;

    // Operand modes of the memory-or-immediate class
    localparam logic [1:0] MODE_IMM = 2'h0;
    localparam logic [1:0] MODE_DIR = 2'h1;
    localparam logic [1:0] MODE_IND = 2'h2;

    // Status word bit positions
    localparam int FLAG_C    = 0;
    localparam int FLAG_HALF = 1;
    localparam int FLAG_IE   = 2;
    localparam logic [2:0] FLAGS_RESET = 3'h0;

    // Register bus map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_PADDR = 8'h04;
    localparam logic [7:0] OFF_PDATA = 8'h08;
    localparam logic [7:0] OFF_STAT  = 8'h0c;
    localparam logic [7:0] OFF_CORE  = 8'h10;
    localparam int CTRL_RUN     = 0;
    localparam int CTRL_VEC_LSB   = 4;
    localparam int STAT_HALT      = 16;
    localparam int CORE_SP_LSB    = 8;
    localparam int CORE_FLAGS_LSB = 16;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_FETCH = 4'h1,
        ST_DEC   = 4'h2,
        ST_B1    = 4'h3,
        ST_B2    = 4'h4,
        ST_EXEC  = 4'h5,
        ST_TABJ  = 4'h6,
        ST_VEC0  = 4'h7,
        ST_VEC1  = 4'h8,
        ST_CALL1 = 4'h9,
        ST_CALL2 = 4'ha,
        ST_RET1  = 4'hb,
        ST_HALT  = 4'hc
    } cfd_state_t;
endpackage

// file: cfd_regs.sv
// AXI4-Lite register slave of the control-flow core
`timescale 1ns/1ps
module cfd_regs import cfd_pkg::*; (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   run,
    output logic [VEC_W-1:0]       vector_index,
    output logic                   pm_we,
    output logic [PC_W-1:0]        pm_addr,
    output logic [7:0]             pm_data,
    input  wire logic [PC_W-1:0]   pc,
    input  wire logic [7:0]        acc,
    input  wire logic [7:0]        sp,
    input  wire logic [2:0]        processor_status_word,
    input  wire logic              halted
);
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              do_write;

    assign do_write = aw_got && w_got && !s_axi_bvalid;

    // Address and data are taken in either order, then answered together
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= '0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got        <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got        <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == OFF_CTRL || aw_addr == OFF_PADDR
                                 || aw_addr == OFF_PDATA) ? RESP_OKAY
                                                          : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Control and program loading; the load address steps after each byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run       <= 1'b0;
            vector_index <= '0;
            pm_we     <= 1'b0;
            pm_addr   <= PC_RESET;
            pm_data   <= 8'h00;
        end else begin
            if (pm_we) begin
                pm_addr <= pm_addr + 15'h0001;
            end
            pm_we <= 1'b0;
            if (do_write && aw_addr == OFF_CTRL && w_strb[0]) begin
                run       <= w_data[CTRL_RUN];
                vector_index <= w_data[CTRL_VEC_LSB +: VEC_W];
            end
            if (do_write && aw_addr == OFF_PADDR) begin
                if (w_strb[0]) pm_addr[7:0] <= w_data[7:0];
                if (w_strb[1]) pm_addr[14:8] <= w_data[14:8];
            end
            if (do_write && aw_addr == OFF_PDATA && w_strb[0]) begin
                pm_we   <= 1'b1;
                pm_data <= w_data[7:0];
            end
        end
    end

    // Reads answer one cycle after the address is taken
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                s_axi_rdata   <= 32'h0000_0000;
                case (s_axi_araddr)
                    OFF_CTRL: begin
                        s_axi_rdata[CTRL_RUN]                <= run;
                        s_axi_rdata[CTRL_VEC_LSB +: VEC_W] <= vector_index;
                    end
                    OFF_PADDR: s_axi_rdata[PC_W-1:0] <= pm_addr;
                    OFF_PDATA: s_axi_rdata[7:0] <= pm_data;
                    OFF_STAT: begin
                        s_axi_rdata[PC_W-1:0]  <= pc;
                        s_axi_rdata[STAT_HALT] <= halted;
                    end
                    OFF_CORE: begin
                        s_axi_rdata[7:0]                <= acc;
                        s_axi_rdata[CORE_SP_LSB +: 8]   <= sp;
                        s_axi_rdata[CORE_FLAGS_LSB +: 3]
                            <= processor_status_word;
                    end
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// file: cfd_core.sv
// Control-flow core: fetch, operands, jumps, calls, skips, AXI top
`timescale 1ns/1ps
module cfd_core import cfd_pkg::*; (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    logic [7:0]       pmem [PMEM_DEPTH];
    logic [7:0]       dmem [DMEM_DEPTH];
    cfd_state_t       state;
    logic [PC_W-1:0]  pc;
    logic [PC_W-1:0]  paddr;
    logic [PC_W-1:0]  link_addr;
    logic [PC_W-1:0]  pc_seq;
    logic [7:0]       pbyte;
    logic [7:0]       acc;
    logic [7:0]       sp;
    logic [2:0]       processor_status_word;
    logic [7:0]       op;
    logic [7:0]       b1;
    logic [7:0]       b2;
    logic [7:0]       vu;
    logic [1:0]       len;
    logic             skip;
    logic             halted;
    logic             run;
    logic [VEC_W-1:0] vector_index;
    logic             pm_we;
    logic [PC_W-1:0]  pm_addr;
    logic [7:0]       pm_data;
    logic             wr_en;
    logic [7:0]       wr_addr;
    logic [7:0]       wr_data;
    logic [7:0]       opnd;
    logic [7:0]       pop_hi;
    logic [7:0]       pop_lo;
    logic [8:0]       adc_sum;
    logic [4:0]       adc_half;

    // Byte length of an opcode; unknown codes are one-byte no-operations
    function automatic logic [1:0] op_len(input logic [7:0] o);
        logic [1:0] l;
        l = LEN1;
        case (o[7:4])
            GRP_NEAR, GRP_LDR: l = LEN2;
            GRP_ADC, GRP_LDA, GRP_IFEQ: l = (o[1:0] == MODE_IND) ? LEN1 : LEN2;
            default: begin
                if (o == OP_FARJ || o == OP_JSRL) l = LEN3;
                else if (o == OP_ST) l = LEN2;
            end
        endcase
        return l;
    endfunction

    // Data read; the stack pointer lives in a reset register, not the RAM
    function automatic logic [7:0] rd(input logic [7:0] a);
        return (a == SP_ADDR) ? sp : dmem[a];
    endfunction

    cfd_regs cfd_regs_inst (
        .clk           (clk),
        .resetn        (resetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .run           (run),
        .vector_index  (vector_index),
        .pm_we         (pm_we),
        .pm_addr       (pm_addr),
        .pm_data       (pm_data),
        .pc            (pc),
        .acc           (acc),
        .sp            (sp),
        .processor_status_word (processor_status_word),
        .halted        (halted)
    );

    // Program memory is loaded over the bus; reads are asynchronous
    always_ff @(posedge clk) begin
        if (pm_we) begin
            pmem[pm_addr] <= pm_data;
        end
    end

    assign pbyte = pmem[paddr];

    // Data RAM has no reset; only the stack pointer needs a known value
    always_ff @(posedge clk) begin
        if (wr_en && wr_addr != SP_ADDR) begin
            dmem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sp <= SP_RESET;
        end else if (wr_en && wr_addr == SP_ADDR) begin
            sp <= wr_data;
        end
    end

    assign len       = op_len(op);
    assign pc_seq    = pc + {13'h0000, len};
    assign link_addr = pc + {13'h0000, LEN3};
    assign adc_sum   = {1'b0, acc} + {1'b0, opnd}
                       + {8'h00, processor_status_word[FLAG_C]};
    assign adc_half  = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]}
                       + {4'h0, processor_status_word[FLAG_C]};

    // Operand and stack reads; a process so that RAM writes refresh them
    always_comb begin
        pop_hi = rd(sp + ONE_B);
        pop_lo = rd(sp + TWO_B);
        case (op[1:0])
            MODE_IMM: opnd = b1;
            MODE_DIR: opnd = rd(b1);
            MODE_IND: opnd = rd(rd(B_ADDR));
            default:  opnd = b1;
        endcase
    end

    // Single data write port; a skipped instruction never reaches it
    always_comb begin
        wr_en   = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        case (state)
            ST_EXEC: begin
                if (!skip) begin
                    if (op == OP_ST) begin
                        wr_en   = 1'b1;
                        wr_addr = b1;
                        wr_data = acc;
                    end else if (op[7:4] == GRP_LDR) begin
                        wr_en   = 1'b1;
                        wr_addr = REG_BASE | {4'h0, op[3:0]};
                        wr_data = b1;
                    end else if (op == OP_JSRL) begin
                        wr_en   = 1'b1;
                        wr_addr = sp;
                        wr_data = link_addr[7:0];
                    end
                end
            end
            ST_CALL1: begin
                wr_en   = 1'b1;
                wr_addr = sp - ONE_B;
                wr_data = {1'b0, pc[14:8]};
            end
            ST_CALL2: begin
                wr_en   = 1'b1;
                wr_addr = SP_ADDR;
                wr_data = sp - TWO_B;
            end
            ST_RET1: begin
                wr_en   = 1'b1;
                wr_addr = SP_ADDR;
                wr_data = sp + TWO_B;
            end
            default: wr_en = 1'b0;
        endcase
    end

    // Sequencer: fetch bytes, then execute or fall through as a skip
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state  <= ST_IDLE;
            pc     <= PC_RESET;
            paddr  <= PC_RESET;
            acc    <= 8'h00;
            processor_status_word <= FLAGS_RESET;
            op     <= OP_NOP;
            b1     <= 8'h00;
            b2     <= 8'h00;
            vu     <= 8'h00;
            skip   <= 1'b0;
            halted <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    halted <= 1'b0;
                    if (run) state <= ST_FETCH;
                end
                ST_FETCH: begin
                    paddr <= pc;
                    state <= run ? ST_DEC : ST_IDLE;
                end
                ST_DEC: begin
                    op <= pbyte;
                    if (op_len(pbyte) != LEN1) begin
                        paddr <= pc + 15'h0001;
                        state <= ST_B1;
                    end else begin
                        state <= ST_EXEC;
                    end
                end
                ST_B1: begin
                    b1 <= pbyte;
                    if (len == LEN3) begin
                        paddr <= pc + 15'h0002;
                        state <= ST_B2;
                    end else begin
                        state <= ST_EXEC;
                    end
                end
                ST_B2: begin
                    b2    <= pbyte;
                    state <= ST_EXEC;
                end
                ST_EXEC: begin
                    state <= ST_FETCH;
                    pc    <= pc_seq;
                    if (skip) begin
                        skip <= 1'b0;
                    end else begin
                        case (op)
                            OP_NOP: pc <= pc_seq;
                            OP_FARJ: pc <= {b1[6:0], b2};
                            OP_TABJ: begin
                                paddr <= {pc[14:8], acc};
                                state <= ST_TABJ;
                            end
                            OP_VSEL: begin
                                paddr <= VEC_BASE
                                         | {10'h000, vector_index, 1'b0};
                                state <= ST_VEC0;
                            end
                            OP_JSRL: state <= ST_CALL1;
                            OP_RTN: begin
                                pc    <= {pop_hi[6:0], pop_lo};
                                state <= ST_RET1;
                            end
                            OP_SC: begin
                                processor_status_word[FLAG_C]    <= 1'b1;
                                processor_status_word[FLAG_HALF] <= 1'b1;
                            end
                            OP_RC: begin
                                processor_status_word[FLAG_C]    <= 1'b0;
                                processor_status_word[FLAG_HALF] <= 1'b0;
                            end
                            OP_IFC:  skip <= !processor_status_word[FLAG_C];
                            OP_IFNC: skip <= processor_status_word[FLAG_C];
                            OP_EI:   processor_status_word[FLAG_IE] <= 1'b1;
                            OP_DI:   processor_status_word[FLAG_IE] <= 1'b0;
                            OP_HALT: state <= ST_HALT;
                            default: begin
                                case (op[7:4])
                                    GRP_NEAR: begin
                                        pc <= {pc[14:12], op[3:0], b1};
                                    end
                                    GRP_ADC: begin
                                        acc <= adc_sum[7:0];
                                        processor_status_word[FLAG_C]
                                            <= adc_sum[8];
                                        processor_status_word[FLAG_HALF]
                                            <= adc_half[4];
                                    end
                                    GRP_LDA: acc <= opnd;
                                    GRP_IFEQ: skip <= (acc != opnd);
                                    default: pc <= pc_seq;
                                endcase
                            end
                        endcase
                    end
                end
                ST_TABJ: begin
                    pc    <= {paddr[14:8], pbyte};
                    state <= ST_FETCH;
                end
                ST_VEC0: begin
                    vu    <= pbyte;
                    paddr <= paddr + 15'h0001;
                    state <= ST_VEC1;
                end
                ST_VEC1: begin
                    pc    <= {vu[6:0], pbyte};
                    state <= ST_FETCH;
                end
                ST_CALL1: state <= ST_CALL2;
                ST_CALL2: begin
                    pc    <= {b1[6:0], b2};
                    state <= ST_FETCH;
                end
                ST_RET1: state <= ST_FETCH;
                ST_HALT: begin
                    halted <= 1'b1;
                    if (!run) state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// file: cfd_monitor.sv
// Bus-side checks of the control-flow core
`timescale 1ns/1ps
module cfd_monitor import cfd_pkg::*; (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence r_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    read_answer_a: assert property (r_take |=> s_axi_rvalid)
        else $error("read not answered");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("bvalid stuck");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready) else $error("read not closed");
    w_block_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken early");
    err_data_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("error read has data");
endmodule

// file: cfd_prog.sv
// Program image standing in program memory, loaded over the bus
`timescale 1ns/1ps
module cfd_prog import cfd_pkg::*; (
    input wire logic [4:0]  idx,
    output logic [PC_W-1:0] addr,
    output logic [7:0]      data
);
    // Entries are {address, byte}; byte at 0x126 is the jump table
    localparam logic [23:0] IMG [32] = '{
        24'h000050, 24'h000126, 24'h000207, 24'h000308, 24'h000450,
        24'h000599, 24'h000600, 24'h000701, 24'h000801, 24'h000900,
        24'h010002, 24'h012632, 24'h013204, 24'h013302, 24'h013400,
        24'h020005, 24'h013503, 24'h01e203, 24'h01e300, 24'h030006,
        24'h030140, 24'h03020a, 24'h03030a, 24'h030423, 24'h030510,
        24'h03103e, 24'h031180, 24'h031261, 24'h0313fe, 24'h031450,
        24'h031577, 24'h03160d};
    assign addr = IMG[idx][22:8];
    assign data = IMG[idx][7:0];
endmodule

// file: test_cpu_control_flow_and_operands.sv
// Bench running a program image through the core's register bus
`timescale 1ns/1ps
module test_cpu_control_flow_and_operands import cfd_pkg::*; ;
    logic clk = 1'b0, resetn = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0] aw = 8'h00, ar = 8'h00;
    logic [31:0] wd = 32'h0, rd, got;
    logic awr, wr, bv, arr, rv;
    logic [1:0] br, rr, rsp;
    logic [PC_W-1:0] pa;
    logic [7:0] pd;
    logic [4:0] idx = 5'h00;
    int errors = 0, samples_checked = 0, cycles = 0;
    always #2.5 clk = ~clk;
    cfd_core cfd_core_inst(.clk(clk), .resetn(resetn), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry));
    cfd_prog cfd_prog_inst(.idx(idx), .addr(pa), .data(pd));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (bv !== 1'b1);
        rsp = br;
        bry <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        ar <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        got = rd;
        rsp = rr;
        rry <= 1'b0;
    endtask
    task automatic t_reset();
        rd_reg(OFF_CORE);
        chk(got, {13'h0, FLAGS_RESET, SP_RESET, 8'h00});
        chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    endtask
    // Skip, jumps, call, vector and add all feed the final core word
    task automatic t_program();
        for (int i = 0; i < 32; i++) begin
            idx = i[4:0];
            #1;
            wr_reg(OFF_PADDR, {17'h0, pa});
            wr_reg(OFF_PDATA, {24'h0, pd});
        end
        wr_reg(OFF_CTRL, 32'h11);
        chk({30'h0, rsp}, {30'h0, RESP_OKAY});
        do rd_reg(OFF_STAT); while (got[STAT_HALT] !== 1'b1);
        chk(got, 32'h0001_0317);
        rd_reg(OFF_CORE);
        chk(got, {13'h0, 3'b110, SP_RESET, 8'h26 + 8'h0a + 8'h01});
    endtask
    task automatic t_unmapped();
        wr_reg(8'h40, 32'hffff_ffff);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        rd_reg(8'h40);
        chk(got, 32'h0);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    endtask
    task automatic close_out();
        if (errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_program();
        t_unmapped();
        close_out();
    end
    // A hang in the program shows up here rather than as a stuck run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            close_out();
        end
    end
endmodule
bind cfd_core cfd_monitor cfd_monitor_inst(.*);
